/* src/comparator_control_registers.sv */
// register bank for two comparators: two control registers and a shared status
// assumes a plain single-cycle strobe bus and comparator results from analog cores
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`include "cmp_regs_cfg.svh"
// Function
// - decode control registers and status at offsets
// - clear, set, toggle aliases at 4, 8, C
// - controls reset to 00C3, status to zero
// - idle-stop bit 13 disables comparators in idle
// - status bit 1 shows comparator two output
// - status bit 0 shows comparator one output
// - unimplemented status bits read zero, ignore writes
// - idle means cpu halted, clocks running
module comparator_control_registers
	import cmp_regs_pkg::*;
(
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	// register bus
	input  wire logic [15:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// comparator cores and power state
	input  wire logic        first_comparator_result_i,
	input  wire logic        second_comparator_result_i,
	input  wire logic        cpu_idle_i,
	output logic      [31:0] comparator_one_control_o,
	output logic      [31:0] comparator_two_control_o,
	output logic             comparator_halt_o
);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// base register of an address, ignoring the alias field
	function automatic reg_sel_type decode_base(input logic [15:0] a);
		logic [15:0] base;
		base = {a[15:4], 4'h0};
		if (a[1:0] != 2'b00)
			decode_base = sel_none;
		else if (base == `CMP_ONE_CTRL_OFS)
			decode_base = sel_one;
		else if (base == `CMP_TWO_CTRL_OFS)
			decode_base = sel_two;
		else if (base == `CMP_STATUS_OFS)
			decode_base = sel_status;
		else
			decode_base = sel_none;
	endfunction : decode_base

	// alias kind sits in address bits 3:2
	function automatic logic [1:0] alias_kind(input logic [15:0] a);
		alias_kind = a[3:2];
	endfunction : alias_kind

	bus_req_type req;
	reg_sel_type sel;
	logic [1:0]  kind;

	assign req  = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	assign sel  = decode_base(req.addr);
	assign kind = alias_kind(req.addr);

	// ----------------------------------------
	// comparator result synchroniser
	// ----------------------------------------
	logic [1:0] result_sync;

	cmp_result_sync #(
		.WIDTH (2)
	) u_sync (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.async_i ({second_comparator_result_i, first_comparator_result_i}),
		.sync_o  (result_sync)
	);

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [31:0] ctrl_one;
	logic [31:0] ctrl_two;
	logic        idle_stop_select;
	logic [31:0] next_ctrl_one;
	logic [31:0] next_ctrl_two;
	logic        next_idle_stop_select;
	logic [31:0] next_rdata;
	logic [31:0] status_view;
	logic [31:0] status_store;
	logic [31:0] upd_one;
	logic [31:0] upd_two;
	logic [31:0] upd_status;

	// status storage holds only the idle-stop bit; results are live
	always_comb begin
		status_store = `CMP_STATUS_RESET;
		status_store[`CMP_IDLE_STOP_BIT] = idle_stop_select;
		status_view = status_store;
		status_view[`CMP_RES_TWO_BIT] = result_sync[1];
		status_view[`CMP_RES_ONE_BIT] = result_sync[0];
	end

	// one alias engine per register keeps the write paths independent
	cmp_alias_update #(.WIDTH (32)) u_upd_one (
		.cur_i    (ctrl_one),
		.data_i   (req.wdata),
		.wmask_i  (`CMP_CTRL_WMASK),
		.kind_i   (kind),
		.result_o (upd_one)
	);

	cmp_alias_update #(.WIDTH (32)) u_upd_two (
		.cur_i    (ctrl_two),
		.data_i   (req.wdata),
		.wmask_i  (`CMP_CTRL_WMASK),
		.kind_i   (kind),
		.result_o (upd_two)
	);

	// mask has only bit 13, so unimplemented bits never change
	cmp_alias_update #(.WIDTH (32)) u_upd_status (
		.cur_i    (status_store),
		.data_i   (req.wdata),
		.wmask_i  (32'h0000_0001 << `CMP_IDLE_STOP_BIT),
		.kind_i   (kind),
		.result_o (upd_status)
	);

	// ----------------------------------------
	// next-state and read mux
	// ----------------------------------------
	always_comb begin
		next_ctrl_one         = ctrl_one;
		next_ctrl_two         = ctrl_two;
		next_idle_stop_select = idle_stop_select;
		next_rdata            = `CMP_READ_ZERO;
		if (req.wr) begin
			unique case (sel)
				sel_one:    next_ctrl_one = upd_one;
				sel_two:    next_ctrl_two = upd_two;
				sel_status: next_idle_stop_select = upd_status[`CMP_IDLE_STOP_BIT];
				sel_none:   next_ctrl_one = ctrl_one;
			endcase
		end
		// aliases read back the base register; unmapped reads give zero
		if (req.rd) begin
			unique case (sel)
				sel_one:    next_rdata = ctrl_one;
				sel_two:    next_rdata = ctrl_two;
				sel_status: next_rdata = status_view;
				sel_none:   next_rdata = `CMP_READ_ZERO;
			endcase
		end
	end

	// read data stand one cycle only, zero otherwise
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_one         <= `CMP_CTRL_RESET;
			ctrl_two         <= `CMP_CTRL_RESET;
			idle_stop_select <= 1'b0;
			rdata_o          <= `CMP_READ_ZERO;
		end else begin
			ctrl_one         <= next_ctrl_one;
			ctrl_two         <= next_ctrl_two;
			idle_stop_select <= next_idle_stop_select;
			rdata_o          <= next_rdata;
		end
	end

	// ----------------------------------------
	// outputs to the comparator cores
	// ----------------------------------------
	logic next_halt;

	// idle means cpu halted with clocks on; halt only if idle-stop set
	always_comb begin
		next_halt = idle_stop_select & cpu_idle_i;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			comparator_halt_o <= 1'b0;
		end else begin
			comparator_halt_o <= next_halt;
		end
	end

	assign comparator_one_control_o = ctrl_one;
	assign comparator_two_control_o = ctrl_two;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence write_one_s;
		wr_i && decode_base(addr_i) == sel_one;
	endsequence

	sequence read_status_s;
		rd_i && decode_base(addr_i) == sel_status;
	endsequence

	reset_values_a: assert property (@(posedge clock_i) $rose(nrst_i) |->
		ctrl_one == `CMP_CTRL_RESET && ctrl_two == `CMP_CTRL_RESET && !idle_stop_select)
		else $error("reset value wrong");

	set_alias_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		write_one_s and (addr_i[3:2] == 2'h2) |=>
		ctrl_one == ($past(ctrl_one) | ($past(wdata_i) & `CMP_CTRL_WMASK)))
		else $error("set alias wrong");

	clear_alias_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		write_one_s and (addr_i[3:2] == 2'h1) |=>
		ctrl_one == ($past(ctrl_one) & ~($past(wdata_i) & `CMP_CTRL_WMASK)))
		else $error("clear alias wrong");

	status_read_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		read_status_s |=> (rdata_o & 32'hFFFF_DFFC) == 32'h0000_0000)
		else $error("reserved status bits not zero");

	result_bits_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		read_status_s ##1 $stable(result_sync) |->
		rdata_o[1:0] == result_sync)
		else $error("result bits wrong");

	idle_bit_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		wr_i && decode_base(addr_i) == sel_status && addr_i[3:2] == `CMP_ALIAS_PLAIN |=>
		idle_stop_select == $past(wdata_i[`CMP_IDLE_STOP_BIT]))
		else $error("idle-stop write wrong");

	halt_follow_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		comparator_halt_o == $past(idle_stop_select & cpu_idle_i))
		else $error("halt output wrong");

	decode_two_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		wr_i && addr_i == `CMP_TWO_CTRL_OFS |=>
		ctrl_one == $past(ctrl_one) && ctrl_two == ($past(wdata_i) & `CMP_CTRL_WMASK))
		else $error("decode of second control wrong");

	read_once_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!rd_i |=> rdata_o == 32'h0000_0000)
		else $error("read data not cleared");

	// ----------------------------------------
	// alias, decode and reset-output checks
	// ----------------------------------------
	// bus phases named once so each property reads as request then effect
	sequence write_two_s;
		wr_i && decode_base(addr_i) == sel_two;
	endsequence

	sequence write_status_s;
		wr_i && decode_base(addr_i) == sel_status;
	endsequence

	sequence write_unmapped_s;
		wr_i && decode_base(addr_i) == sel_none;
	endsequence

	sequence read_control_s;
		rd_i && (decode_base(addr_i) == sel_one || decode_base(addr_i) == sel_two);
	endsequence

	// toggle alias flips only the writable ones that were written
	toggle_alias_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		write_one_s and (addr_i[3:2] == `CMP_ALIAS_TOGGLE) |=>
		ctrl_one == ($past(ctrl_one) ^ ($past(wdata_i) & `CMP_CTRL_WMASK)))
		else $error("toggle alias wrong");

	// second control has its own engine, so its set path is checked too
	set_two_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		write_two_s and (addr_i[3:2] == `CMP_ALIAS_SET) |=>
		ctrl_two == ($past(ctrl_two) | ($past(wdata_i) & `CMP_CTRL_WMASK)))
		else $error("set alias on second control wrong");

	// a hole in the map must not disturb any stored bit
	unmapped_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		write_unmapped_s |=>
		$stable(ctrl_one) && $stable(ctrl_two) && $stable(idle_stop_select))
		else $error("unmapped write changed state");

	// status writes reach only the idle-stop bit, never the controls
	status_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		write_status_s |=> $stable(ctrl_one) && $stable(ctrl_two))
		else $error("status write leaked into controls");

	// clear alias drops idle-stop only when its bit is written as one
	idle_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		write_status_s and (addr_i[3:2] == `CMP_ALIAS_CLEAR) |=>
		idle_stop_select ==
		($past(idle_stop_select) & !$past(wdata_i[`CMP_IDLE_STOP_BIT])))
		else $error("idle-stop clear alias wrong");

	// toggle alias flips idle-stop when its bit is written as one
	idle_toggle_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		write_status_s and (addr_i[3:2] == `CMP_ALIAS_TOGGLE) |=>
		idle_stop_select ==
		($past(idle_stop_select) ^ $past(wdata_i[`CMP_IDLE_STOP_BIT])))
		else $error("idle-stop toggle alias wrong");

	// any control address, alias or base, reads back the stored word
	control_read_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		read_control_s |=>
		rdata_o == (($past(sel) == sel_two) ? $past(ctrl_two) : $past(ctrl_one)))
		else $error("control read data wrong");

	// outputs leave reset quiet: no stale read word, comparators not halted
	reset_outputs_a: assert property (@(posedge clock_i) $rose(nrst_i) |->
		rdata_o == `CMP_READ_ZERO && !comparator_halt_o)
		else $error("outputs not quiet after reset");

endmodule : comparator_control_registers

/* src/cmp_regs_cfg.svh */
// constants for the comparator register bank: offsets, field positions, resets
// assumes word-aligned byte addresses on a 16-bit offset bus
`ifndef CMP_REGS_CFG_SVH
`define CMP_REGS_CFG_SVH

// ----------------------------------------
// register offsets and alias steps
// ----------------------------------------
`define CMP_ONE_CTRL_OFS   16'hC000
`define CMP_TWO_CTRL_OFS   16'hC010
`define CMP_STATUS_OFS     16'hC060
`define CMP_ALIAS_PLAIN    2'h0
`define CMP_ALIAS_CLEAR    2'h1
`define CMP_ALIAS_SET      2'h2
`define CMP_ALIAS_TOGGLE   2'h3

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define CMP_CTRL_RESET     32'h0000_00C3
`define CMP_STATUS_RESET   32'h0000_0000
`define CMP_CTRL_WMASK     32'h0000_E0F3
`define CMP_IDLE_STOP_BIT  13
`define CMP_RES_TWO_BIT    1
`define CMP_RES_ONE_BIT    0
`define CMP_READ_ZERO      32'h0000_0000

`endif

/* src/cmp_regs_pkg.sv */
// types shared by the comparator register bank
// assumes cmp_regs_cfg.svh supplies the numbers
package cmp_regs_pkg;

	// ----------------------------------------
	// bus request carrier
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_type;

	typedef enum logic [1:0] {
		sel_none,
		sel_one,
		sel_two,
		sel_status
	} reg_sel_type;

endpackage : cmp_regs_pkg

/* src/cmp_alias_update.sv */
// applies a plain, clear, set or toggle write to one register value
// assumes the caller gives the mask of writable bits
`timescale 1ns/1ns
`include "cmp_regs_cfg.svh"
module cmp_alias_update
	import cmp_regs_pkg::*;
#(
	parameter int WIDTH = 32
) (
	// request
	input  wire logic [WIDTH-1:0] cur_i,
	input  wire logic [WIDTH-1:0] data_i,
	input  wire logic [WIDTH-1:0] wmask_i,
	input  wire logic [1:0]       kind_i,
	// result
	output logic      [WIDTH-1:0] result_o
);

	// ----------------------------------------
	// alias arithmetic
	// ----------------------------------------
	// only writable bits change; others keep current value
	always_comb begin
		unique case (kind_i)
			`CMP_ALIAS_PLAIN:  result_o = (cur_i & ~wmask_i) | (data_i & wmask_i);
			`CMP_ALIAS_CLEAR:  result_o = cur_i & ~(data_i & wmask_i);
			`CMP_ALIAS_SET:    result_o = cur_i | (data_i & wmask_i);
			`CMP_ALIAS_TOGGLE: result_o = cur_i ^ (data_i & wmask_i);
		endcase
	end

endmodule : cmp_alias_update

/* src/cmp_result_sync.sv */
// two-flop synchroniser for the analog comparator results
// assumes results arrive asynchronously from the analog cores
`timescale 1ns/1ns
module cmp_result_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	// async in, synced out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage;
	logic [WIDTH-1:0] next_stage;
	logic [WIDTH-1:0] next_sync;

	// ----------------------------------------
	// two stages; first stage feeds only the second
	// ----------------------------------------
	always_comb begin
		next_stage = async_i;
		next_sync  = stage;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stage  <= '0;
			sync_o <= '0;
		end else begin
			stage  <= next_stage;
			sync_o <= next_sync;
		end
	end

endmodule : cmp_result_sync

/* bench/comparator_control_registers_bench.sv */
// self-checking bench for the comparator register bank
// assumes the design sources and cmp_regs_cfg.svh are compiled first; bench drives all ports
`timescale 1ns/1ns
`include "cmp_regs_cfg.svh"
module comparator_control_registers_bench
	import cmp_regs_pkg::*;
;
	// ----------------------------------------
	// stimulus, model and scoreboard state
	// ----------------------------------------
	logic        clock_i = 1'b0;
	logic        nrst_i  = 1'b0;
	logic [15:0] addr    = 16'h0000;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic        rd_q    = 1'b0;
	logic        res_one = 1'b0;
	logic        res_two = 1'b0;
	logic        idle    = 1'b0;
	logic [31:0] rdata;
	logic [31:0] ctl_one;
	logic [31:0] ctl_two;
	logic        halt;
	logic [31:0] model [3];
	logic [31:0] exp_q [$];
	int          err_count = 0;
	int          comparisons = 0;

	always #2 clock_i = ~clock_i;

	comparator_control_registers uut (
		.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .first_comparator_result_i(res_one),
		.second_comparator_result_i(res_two), .cpu_idle_i(idle),
		.comparator_one_control_o(ctl_one), .comparator_two_control_o(ctl_two),
		.comparator_halt_o(halt)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic int idx(input logic [15:0] a);
		case (a[15:4])
			12'hC00: return 0;
			12'hC01: return 1;
			12'hC06: return 2;
			default: return 3;
		endcase
	endfunction : idx

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	// one-cycle write; model follows plain, clear, set or toggle on writable bits
	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		int          i;
		logic [31:0] m;
		i = idx(a);
		@(posedge clock_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		if (i < 3) begin
			m = (i < 2) ? `CMP_CTRL_WMASK : 32'h0000_2000;
			case (a[3:2])
				2'h0: model[i] = (model[i] & ~m) | (d & m);
				2'h1: model[i] = model[i] & ~(d & m);
				2'h2: model[i] = model[i] | (d & m);
				default: model[i] = model[i] ^ (d & m);
			endcase
		end
		@(posedge clock_i);
		wr <= 1'b0;
	endtask : wr_reg

	// read; expected word queued for the monitor, unmapped reads zero
	task automatic rd_reg(input logic [15:0] a);
		int i;
		i = idx(a);
		@(posedge clock_i);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(i == 2 ? model[2] | {30'h0, res_two, res_one} : i < 2 ? model[i] : 0);
		@(posedge clock_i);
		rd <= 1'b0;
	endtask : rd_reg

	task automatic ctl_chk();
		@(negedge clock_i);
		chk(model[0], ctl_one);
		chk(model[1], ctl_two);
	endtask : ctl_chk

	// read data stands only in the cycle after the strobe, so look mid-cycle
	always @(posedge clock_i) rd_q <= rd;
	always @(negedge clock_i) if (rd_q) chk(exp_q.pop_front(), rdata);

	task automatic tally_and_finish();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int k;
		void'($urandom(32'hdf58b0a8));
		model[0] = `CMP_CTRL_RESET;
		model[1] = `CMP_CTRL_RESET;
		model[2] = `CMP_STATUS_RESET;
		repeat (12) @(posedge clock_i);
		nrst_i <= 1'b1;
		rd_reg(16'hC000);
		rd_reg(16'hC010);
		rd_reg(16'hC060);
		rd_reg(16'hC020);
		// every alias kind on both controls; bit 8 left alone as it is read-only
		for (k = 0; k < 8; k++) begin
			wr_reg(16'hC000 + 16'(k / 4) * 16'h0010 + 16'(k % 4) * 16'h0004,
				$urandom() & 32'hFFFF_FEFF);
			ctl_chk();
			rd_reg(16'hC000 + 16'(k / 4) * 16'h0010);
		end
		rd_reg(16'hC01C);
		wr_reg(16'hC020, 32'hFFFF_FFFF);
		ctl_chk();
		wr_reg(16'hC060, 32'hFFFF_FFFF);
		rd_reg(16'hC060);
		wr_reg(16'hC06C, 32'hFFFF_FFFF);
		rd_reg(16'hC060);
		// results cross two flops, so let them settle before reading
		for (k = 0; k < 4; k++) begin
			res_one <= k[0];
			res_two <= k[1];
			repeat (4) @(posedge clock_i);
			rd_reg(16'hC060);
		end
		// halt only when idle-stop is set and the cpu sits in idle
		wr_reg(16'hC068, 32'h0000_2000);
		repeat (3) @(negedge clock_i);
		chk(32'h0, {31'h0, halt});
		@(posedge clock_i);
		idle <= 1'b1;
		repeat (3) @(negedge clock_i);
		chk(32'h1, {31'h0, halt});
		wr_reg(16'hC064, 32'h0000_2000);
		repeat (3) @(negedge clock_i);
		chk(32'h0, {31'h0, halt});
		// second reset in mid-run
		@(posedge clock_i);
		nrst_i  <= 1'b0;
		res_one <= 1'b0;
		res_two <= 1'b0;
		model[0] = `CMP_CTRL_RESET;
		model[1] = `CMP_CTRL_RESET;
		model[2] = `CMP_STATUS_RESET;
		repeat (3) @(posedge clock_i);
		nrst_i <= 1'b1;
		ctl_chk();
		rd_reg(16'hC060);
		tally_and_finish();
	end

	// watchdog at 2000 cycles, well beyond the hundred or so cycles the sequence needs
	initial begin
		#(4 * 2000);
		err_count++;
		tally_and_finish();
	end

endmodule : comparator_control_registers_bench
